// [hw/dram_rom_ems_defs.vh]
`ifndef DRAM_ROM_EMS_DEFS_VH
`define DRAM_ROM_EMS_DEFS_VH
`define ROM_HI_BASE      20'hfe000
`define ROM_HI_TOP       20'hfffff
`define ROM_LO_BASE      20'hf6000
`define ROM_LO_TOP       20'hfdfff
`define SYS_TOP_STD      20'h9ffff
`define EMS_BASE         20'hd0000
`define EMS_TOP          20'hdffff
`define MA_W             10
`define BANKS            10
`define CAS_W            8
`define PAGE_BIT         5
`define PH_IDLE          2'h0
`define PH_ROW           2'h1
`define PH_COL           2'h2
`define PH_CAS           2'h3
`define WR_EXTRA         2'h1
`define PAR_CHECK        3'h4
`define PAR_DONE         3'h5
`endif

// [hw/pin_sync.v]
`timescale 1ns/1ps
// Three-stage synchroniser; output changes only once stages two and three
// agree, so a single-cycle glitch out of stage one is never accepted.
module pin_sync (
  input  wire ref_clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  always @(posedge ref_clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout  <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end
endmodule

// [hw/dram_rom_ems_decoder.v]
`timescale 1ns/1ps
`include "dram_rom_ems_defs.vh"
// Functional notes
// R01 - Parity error output driven from checker
// R02 - Channel check low on expanded parity error
// R03 - System RAM errors never hit channel check
// R04 - Processor clock references cycle timing
// R05 - Strobe timing from triple-rate clock; input is never read, sequencer steps once per ref_clk cycle
// R06 - Delay-line select switches timing source
// R07 - Address tap low selects column address
// R08 - Column tap gates column strobes
// R09 - Upper ROM select FE000 to FFFFF
// R10 - Lower ROM select F6000 to FDFFF
// R11 - Ten row strobes, one per bank
// R12 - Ten-bit muxed address plus bit8 copy
// R13 - Small DRAM type select changes organisation
// R14 - Megabit select splits 640K/384K
// R15 - Buffer direction low on device/RAM reads
// R16 - RAM access flag low on RAM access
// R17 - Expanded valid low on expanded access
// R18 - Inverted page bit5 during expanded access
// R19 - Board may decode CAS with page bit
// R20 - DMA page drives A19-A16 when enabled
// R21 - Parity bit exchanged on data bit 8
// R22 - Two switches select system RAM size
// R23 - Three switches per expansion board
// R24 - Parity generated on write, checked on read
// R25 - Write column strobe delayed versus read
module dram_rom_ems_decoder (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [19:0] cpuAddr,
  input  wire [7:0]  cpuDataIn,
  input  wire        memRd_n,
  input  wire        memWr_n,
  input  wire        ioRd_n,
  input  wire        triple_rate_clock_in,
  input  wire        timing_source_select,
  input  wire        address_tap_in,
  input  wire        column_tap_in,
  input  wire        small_dram_type_select,
  input  wire        megabit_dram_select,
  input  wire        ram_size_switch_a,
  input  wire        ram_size_switch_b,
  input  wire [8:0]  expansion_board_addr_switches,
  input  wire [5:0]  activePage,
  input  wire [3:0]  dmaPage,
  input  wire        dma_addr_enable,
  input  wire        parityDataIn,
  output reg         parity_error_out,
  output reg         channelCheckOut,
  output reg         channelCheckOe,
  output reg         upper_rom_select,
  output reg         lower_rom_select,
  output reg  [9:0]  rowStrobe_n,
  output reg  [7:0]  colStrobe_n,
  output reg  [9:0]  dram_mux_addr,
  output reg         dram_mux_addr_bit8_copy,
  output reg         bufferDir,
  output reg         ram_access_flag,
  output reg         expanded_access_valid,
  output reg         page_bit5_inverted,
  output reg  [3:0]  dmaAddrOut,
  output reg         dmaAddrOe,
  output reg         parityDataOut,
  output reg         parityDataOe,
  output reg  [2:0]  boardSel
);
  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  // Reset is active low at the pin; internally used as a sync high reset.
  wire rst;
  wire rdS;
  wire wrS;
  wire aTapS;
  wire cTapS;
  wire parS;
  assign rst = ~rst_n;
  pin_sync uRd (.ref_clk(ref_clk), .rst(rst), .din(~memRd_n), .dout(rdS));
  pin_sync uWr (.ref_clk(ref_clk), .rst(rst), .din(~memWr_n), .dout(wrS));
  pin_sync uAt (.ref_clk(ref_clk), .rst(rst), .din(address_tap_in),
                .dout(aTapS));
  pin_sync uCt (.ref_clk(ref_clk), .rst(rst), .din(column_tap_in),
                .dout(cTapS));
  pin_sync uPa (.ref_clk(ref_clk), .rst(rst), .din(parityDataIn),
                .dout(parS));

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function inRange;
    input [19:0] a;
    input [19:0] lo;
    input [19:0] hi;
    begin
      inRange = (a >= lo) && (a <= hi);
    end
  endfunction

  wire [19:0] sysTop;
  wire        isUpperRom;
  wire        isLowerRom;
  wire        isSys;
  wire        isEms;
  wire        isRam;
  wire        access;
  wire        romRd;
  // Size switches shrink system RAM in 128K steps below 640K; a megabit
  // part always provides the full 640K and the rest as expanded memory.
  assign sysTop = megabit_dram_select ? `SYS_TOP_STD :                  // R14
                  (`SYS_TOP_STD - {1'b0, ram_size_switch_b,             // R22
                   ram_size_switch_a, 17'h00000});
  assign isUpperRom = inRange(cpuAddr, `ROM_HI_BASE, `ROM_HI_TOP);      // R09
  assign isLowerRom = inRange(cpuAddr, `ROM_LO_BASE, `ROM_LO_TOP);      // R10
  assign isSys = cpuAddr <= sysTop;
  assign isEms = inRange(cpuAddr, `EMS_BASE, `EMS_TOP);
  assign isRam = isSys | isEms;
  assign access = rdS | wrS;
  assign romRd = rdS & (isUpperRom | isLowerRom);

  // ------------------------------------------------------------------
  // Strobe sequencer
  // ------------------------------------------------------------------
  reg [1:0] phase_ff;
  reg [1:0] nxt_phase;
  reg [1:0] wrWait_ff;
  reg       cycEms_ff;
  reg [2:0] casCnt_ff;
  wire      toCol;
  wire      casOk;
  // The triple-rate clock is phase locked to this clock, so it cannot be
  // sampled here; its three periods per cycle are taken as one step each
  // cycle. Delay-line mode takes its steps from the synchronised taps.
  assign toCol = timing_source_select ? ~aTapS : 1'b1;        // R05 R06 R07
  assign casOk = timing_source_select ? cTapS : 1'b1;            // R05 R08

  always @* begin
    nxt_phase = phase_ff;
    case (phase_ff)
      `PH_IDLE: if (access & isRam) nxt_phase = `PH_ROW;
      `PH_ROW:  if (toCol) nxt_phase = `PH_COL;
      `PH_COL:  if (casOk && (!wrS || wrWait_ff == `WR_EXTRA))   // R25
                  nxt_phase = `PH_CAS;
      `PH_CAS:  if (!access) nxt_phase = `PH_IDLE;
      default:  nxt_phase = `PH_IDLE;
    endcase
    if (!access) nxt_phase = `PH_IDLE;
  end

  // Bank from address: 64K per bank on small parts, else 256K per bank.
  wire [3:0] bank;
  assign bank = isEms ? 4'h9 :
                small_dram_type_select ? {1'b0, cpuAddr[18:16]} :    // R13
                {2'b00, cpuAddr[19:18]};

  always @(posedge ref_clk) begin
    if (rst) begin
      phase_ff    <= `PH_IDLE;
      casCnt_ff   <= 3'h0;
      wrWait_ff   <= 2'h0;
      cycEms_ff   <= 1'b0;
      rowStrobe_n <= 10'h3ff;
      colStrobe_n <= 8'hff;
      dram_mux_addr <= 10'h000;
      dram_mux_addr_bit8_copy <= 1'b0;
    end else begin
      phase_ff  <= nxt_phase;
      if (phase_ff != `PH_CAS)
        casCnt_ff <= 3'h0;
      else if (casCnt_ff != `PAR_DONE)
        casCnt_ff <= casCnt_ff + 3'h1;
      if (phase_ff == `PH_COL && wrS && wrWait_ff != `WR_EXTRA)
        wrWait_ff <= wrWait_ff + 2'h1;
      else if (phase_ff != `PH_COL)
        wrWait_ff <= 2'h0;
      if (phase_ff == `PH_IDLE)
        cycEms_ff <= isEms;
      rowStrobe_n <= 10'h3ff;
      if (nxt_phase != `PH_IDLE)
        rowStrobe_n[bank] <= 1'b0;                               // R11
      colStrobe_n <= (nxt_phase == `PH_CAS) ? 8'h00 : 8'hff;
      if (nxt_phase == `PH_ROW || nxt_phase == `PH_IDLE) begin
        dram_mux_addr <= cpuAddr[`MA_W-1:0];                     // R12
        dram_mux_addr_bit8_copy <= cpuAddr[8];
      end else begin
        dram_mux_addr <= cpuAddr[19:`MA_W];
        dram_mux_addr_bit8_copy <= cpuAddr[18];
      end
    end
  end

  // ------------------------------------------------------------------
  // Parity and channel check
  // ------------------------------------------------------------------
  // Parity is checked once, late in the CAS phase, after the DRAM bit
  // has passed the synchroniser; an earlier look would see a stale bit.
  wire parityBit;
  wire parityErr;
  assign parityBit = ~^cpuDataIn;                                 // R24
  assign parityErr = (phase_ff == `PH_CAS) && (casCnt_ff == `PAR_CHECK) &&
                     rdS && (parS != parityBit);                  // R24

  always @(posedge ref_clk) begin
    if (rst) begin
      parity_error_out <= 1'b0;
      channelCheckOut  <= 1'b0;
      channelCheckOe   <= 1'b0;
      parityDataOut    <= 1'b0;
      parityDataOe     <= 1'b0;
    end else begin
      parity_error_out <= parityErr;                              // R01
      parityDataOut <= parityBit;                                 // R21
      parityDataOe  <= wrS & isRam;
      // Set beats the write release so an error is never lost.
      if (parityErr & cycEms_ff)                                  // R02 R03
        channelCheckOe <= 1'b1;
      else if (wrS)
        channelCheckOe <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Select, buffer and DMA outputs
  // ------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      upper_rom_select      <= 1'b1;
      lower_rom_select      <= 1'b1;
      bufferDir             <= 1'b1;
      ram_access_flag       <= 1'b1;
      expanded_access_valid <= 1'b1;
      page_bit5_inverted    <= 1'b1;
      dmaAddrOut            <= 4'h0;
      dmaAddrOe             <= 1'b0;
      boardSel              <= 3'h0;
    end else begin
      upper_rom_select <= ~(access & isUpperRom);
      lower_rom_select <= ~(access & isLowerRom);
      bufferDir <= ~((rdS & isRam) | romRd | ~ioRd_n);           // R15
      ram_access_flag <= ~(access & isRam);                      // R16
      expanded_access_valid <= ~(access & isEms);                // R17
      page_bit5_inverted <= (access & isEms) ?                   // R18
                            ~activePage[`PAGE_BIT] : 1'b1;
      dmaAddrOut <= dmaPage;                                     // R20
      dmaAddrOe  <= ~dma_addr_enable;
      // Board address picks from three switch groups by page bits 4 and 3.
      case (activePage[4:3])                                     // R23
        2'h0:    boardSel <= expansion_board_addr_switches[2:0];
        2'h1:    boardSel <= expansion_board_addr_switches[5:3];
        default: boardSel <= expansion_board_addr_switches[8:6];
      endcase
    end
  end
endmodule

// [tb/dram_rom_ems_checker_properties.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Output relations of the decoder
// ------------------------------------------------------------
module dram_rom_ems_checker (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [19:0] cpuAddr,
  input wire        memWr_n,
  input wire [5:0]  activePage,
  input wire [3:0]  dmaPage,
  input wire        dma_addr_enable,
  input wire        parity_error_out,
  input wire        channelCheckOut,
  input wire        channelCheckOe,
  input wire        upper_rom_select,
  input wire        lower_rom_select,
  input wire [9:0]  rowStrobe_n,
  input wire [7:0]  colStrobe_n,
  input wire        ram_access_flag,
  input wire        expanded_access_valid,
  input wire        page_bit5_inverted,
  input wire [3:0]  dmaAddrOut,
  input wire        dmaAddrOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_hi; !upper_rom_select |-> cpuAddr >= 20'hfe000; endproperty
  a_hi: assert property (p_hi) else $error("upper select range");
  property p_lo; !lower_rom_select |-> cpuAddr inside
    {[20'hf6000:20'hfdfff]}; endproperty
  a_lo: assert property (p_lo) else $error("lower select range");
  property p_romras; !upper_rom_select || !lower_rom_select |->
    rowStrobe_n == 10'h3ff; endproperty
  a_romras: assert property (p_romras) else $error("ras on rom");
  property p_ems; !expanded_access_valid |-> !ram_access_flag &&
    page_bit5_inverted == !activePage[5]; endproperty
  a_ems: assert property (p_ems) else $error("expanded flags");
  property p_cas; colStrobe_n != 8'hff |-> rowStrobe_n != 10'h3ff;
  endproperty
  a_cas: assert property (p_cas) else $error("cas without ras");
  property p_pe; parity_error_out |=> !parity_error_out; endproperty
  a_pe: assert property (p_pe) else $error("parity pulse long");
  property p_ccl; channelCheckOe |-> !channelCheckOut; endproperty
  a_ccl: assert property (p_ccl) else $error("check not low");
  property p_cch; channelCheckOe && $past(memWr_n, 2) &&
    $past(memWr_n, 3) |=> channelCheckOe; endproperty
  a_cch: assert property (p_cch) else $error("check dropped");
  property p_dma; !dma_addr_enable && $past(dma_addr_enable) == 1'b0 |->
    dmaAddrOe && dmaAddrOut == dmaPage; endproperty
  a_dma: assert property (p_dma) else $error("dma page out");
endmodule

// [tb/dram_bit8_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Parity bit cell of the DRAM array
// ------------------------------------------------------------
module dram_bit8_model (
  input  wire       ref_clk,
  input  wire [7:0] colStrobe_n,
  input  wire       parityDataOut,
  input  wire       parityDataOe,
  input  wire       flipParity,
  output logic      parityDataIn
);
  logic stored = 1'b0;
  logic lastOut = 1'b0;
  always @(posedge ref_clk) begin
    if (colStrobe_n != 8'hff && parityDataOe) stored <= parityDataOut;
    lastOut <= parityDataIn;
  end
  // Undriven, the line toggles, so sampling outside a read cannot pass.
  always @* begin
    if (colStrobe_n != 8'hff && !parityDataOe) parityDataIn = stored ^ flipParity;
    else parityDataIn = ~lastOut;
  end
endmodule

// [tb/dram_rom_ems_decoder_bench.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module dram_rom_ems_decoder_bench;
  logic ref_clk = 1'b0, rst_n = 1'b0, triClk = 1'b0, sawPe = 1'b0;
  logic [19:0] cpuAddr = 20'h00000;
  logic [7:0] cpuDataIn = 8'h00;
  logic memRd_n = 1'b1, memWr_n = 1'b1, dma_addr_enable = 1'b1, flip = 1'b0;
  logic tsel = 1'b0, atap = 1'b1, ctap = 1'b0;
  logic [5:0] activePage = 6'h20;
  logic [3:0] dmaPage = 4'ha;
  logic [8:0] boardSw = 9'h0a5;
  wire parity_error_out, channelCheckOe, upper_rom_select, lower_rom_select;
  wire bufferDir, ram_access_flag, expanded_access_valid, page_bit5_inverted;
  wire dmaAddrOe, parityDataOut, parityDataOe, parityDataIn;
  wire [9:0] rowStrobe_n, dram_mux_addr;
  wire [7:0] colStrobe_n;
  wire [3:0] dmaAddrOut;
  int n_fail = 0, n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  always #4.1667 triClk = ~triClk;
  always @(posedge ref_clk) if (parity_error_out === 1'b1) sawPe <= 1'b1;
  dram_rom_ems_decoder dram_rom_ems_decoder_inst (.*, .ioRd_n(1'b1),
    .triple_rate_clock_in(triClk), .timing_source_select(tsel),
    .address_tap_in(atap), .column_tap_in(ctap),
    .small_dram_type_select(1'b0), .megabit_dram_select(1'b0),
    .ram_size_switch_a(1'b0), .ram_size_switch_b(1'b0),
    .expansion_board_addr_switches(boardSw), .channelCheckOut(),
    .dram_mux_addr_bit8_copy(), .boardSel());
  dram_bit8_model dram_bit8_model_inst (.ref_clk(ref_clk),
    .colStrobe_n(colStrobe_n), .parityDataOut(parityDataOut),
    .parityDataOe(parityDataOe), .flipParity(flip),
    .parityDataIn(parityDataIn));
  task complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n); repeat (n) @(posedge ref_clk); #2; endtask
  // Strobe held ten cycles covers the sync delay and the whole walk.
  task start(input logic [19:0] a, input logic w);
    tick(1); cpuAddr = a; memWr_n = !w; memRd_n = w; tick(10);
  endtask
  task stop; memRd_n = 1'b1; memWr_n = 1'b1; tick(8); endtask
  task rom_ranges;
    start(20'hfe000, 1'b0); chk(upper_rom_select, 1'b0);
    chk(rowStrobe_n, 10'h3ff); stop;
    start(20'hfdfff, 1'b0); chk(upper_rom_select, 1'b1);
    chk(lower_rom_select, 1'b0); stop;
    start(20'hf5fff, 1'b0); chk(lower_rom_select, 1'b1); stop;
  endtask
  task ram_read;
    start(20'h12345, 1'b0); chk(ram_access_flag, 1'b0);
    chk(bufferDir, 1'b0);
    chk(&rowStrobe_n, 1'b0);
    chk(expanded_access_valid, 1'b1);
    chk(dram_mux_addr, 10'h048); stop;
  endtask
  task ems_pages;
    for (int i = 0; i < 2; i++) begin
      activePage = i ? 6'h05 : 6'h20;
      start(20'hd1234, 1'b0); chk(expanded_access_valid, 1'b0);
      chk(page_bit5_inverted, i);
      chk(ram_access_flag, 1'b0); stop;
    end
  endtask
  task bad_read(input logic [19:0] a);
    cpuDataIn = 8'h5a; start(a, 1'b1); stop;
    flip = 1'b1; sawPe = 1'b0; start(a, 1'b0); stop; flip = 1'b0;
  endtask
  task parity;
    bad_read(20'h01000); chk(sawPe, 1'b1);
    chk(channelCheckOe, 1'b0);
    bad_read(20'hd0010); chk(channelCheckOe, 1'b1);
    sawPe = 1'b0; start(20'hd0010, 1'b0); stop; chk(sawPe, 1'b0);
    chk(channelCheckOe, 1'b1);
    start(20'hd0010, 1'b1); stop; chk(channelCheckOe, 1'b0);
  endtask
  task delay_line;
    tsel = 1'b1; start(20'h12345, 1'b0); chk(dram_mux_addr, 10'h345);
    chk(&colStrobe_n, 1'b1);
    atap = 1'b0; tick(6); chk(dram_mux_addr, 10'h048);
    ctap = 1'b1; tick(6); chk(&colStrobe_n, 1'b0); stop;
    tsel = 1'b0; atap = 1'b1; ctap = 1'b0;
  endtask
  task dma_page;
    dma_addr_enable = 1'b0; tick(3); chk(dmaAddrOe, 1'b1);
    chk(dmaAddrOut, 4'ha);
    dma_addr_enable = 1'b1; tick(3); chk(dmaAddrOe, 1'b0);
  endtask
  initial begin
    tick(6); rst_n = 1'b1; tick(6);
    rom_ranges; ram_read; ems_pages; parity; delay_line; dma_page;
    complete_run;
  end
  initial begin
    #200000; n_fail++; complete_run;
  end
endmodule
bind dram_rom_ems_decoder dram_rom_ems_checker chk_inst (.*);
